// *** design/twi_pkg.sv ***
// twi_pkg: constants shared by the interrupt request flag logic
// assumes: no other package; every user writes twi_pkg::name
package twi_pkg;

	// bit counter of one serial frame
	localparam int unsigned CNT_W       = 4;
	localparam logic [3:0]  CNT_ZERO    = 4'h0;
	localparam logic [3:0]  CNT_ONE     = 4'h1;
	localparam logic [3:0]  CNT_SEVEN   = 4'h7;
	localparam logic [3:0]  CNT_EIGHT   = 4'h8;
	localparam logic [3:0]  CNT_NINE    = 4'h9;

	// format decode of {format_select, second_format_select}
	localparam logic [1:0]  FMT_SYNC    = 2'h3;

	// end condition mask level that lets the stop event through
	localparam logic        END_MASK_EN = 1'h0;

	// control register layout as software reads it
	localparam int unsigned CTRL_W      = 8;
	localparam int unsigned FLAG_POS    = 1;
	localparam logic        FLAG_RST    = 1'h0;
	localparam logic        CLEAR_VAL   = 1'h0;

	// indices of the watched status flags
	localparam int unsigned N_FLAGS     = 9;
	localparam int unsigned F_TXE       = 0;
	localparam int unsigned F_RXF       = 1;
	localparam int unsigned F_ACK       = 2;
	localparam int unsigned F_ARB       = 3;
	localparam int unsigned F_AM        = 4;
	localparam int unsigned F_AM2       = 5;
	localparam int unsigned F_GC        = 6;
	localparam int unsigned F_STOP      = 7;
	localparam int unsigned F_ERROR_END_SEEN_FLAG      = 8;

	// frame phase, gray coded along idle -> address -> data
	typedef enum logic [1:0] {
		TWI_IDLE = 2'h0,
		TWI_ADDR = 2'h1,
		TWI_DATA = 2'h3
	} twi_phase_e;

endpackage

// *** design/twi_line_sense.sv ***
// twi_line_sense: samples the two bus lines and reports edges
// assumes: lines arrive asynchronously; one system clock domain
`timescale 1ns/10ps
`default_nettype none

module twi_line_sense (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	// bus lines
	input  wire logic scl_i,
	input  wire logic sda_i,
	// decoded line events, one-cycle pulses
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      start_det_o,
	output logic      stop_det_o
);

	typedef struct packed {
		logic [1:0] scl_meta;
		logic [1:0] sda_meta;
		logic       scl_s;
		logic       sda_s;
		logic       scl_p;
		logic       sda_p;
	} twi_sense_s;

	twi_sense_s st_q;
	twi_sense_s st_d;

	////////////////////////////////////////////////////////////////
	// first stage feeds only the second; edges use the later copies
	always_comb begin
		st_d          = st_q;
		st_d.scl_meta = {st_q.scl_meta[0], scl_i};
		st_d.sda_meta = {st_q.sda_meta[0], sda_i};
		st_d.scl_s    = st_q.scl_meta[1];
		st_d.sda_s    = st_q.sda_meta[1];
		st_d.scl_p    = st_q.scl_s;
		st_d.sda_p    = st_q.sda_s;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q <= '{scl_meta: 2'h3, sda_meta: 2'h3, default: 1'h1};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////
	assign scl_rise_o  = st_q.scl_s & ~st_q.scl_p;
	assign scl_fall_o  = ~st_q.scl_s & st_q.scl_p;
	// sda moving while scl stays high marks start or stop
	assign start_det_o = st_q.scl_s & st_q.scl_p & ~st_q.sda_s & st_q.sda_p;
	assign stop_det_o  = st_q.scl_s & st_q.scl_p & st_q.sda_s & ~st_q.sda_p;

endmodule

`default_nettype wire

// *** design/twi_irq_flag.sv ***
// twi_irq_flag: interrupt request flag of the two-wire module
// assumes: status flags come from controller logic on sys_clk_i;
// bus lines come from pins and are synchronised in twi_line_sense
//
// What this block does
// - flag tells cpu the module requests interrupt
// - set timing follows format, wait, ack check
// - master start seen with tx empty sets
// - wait mode: sets at 8th clock fall
// - no wait: sets at 9th clock rise
// - arbitration lost: sets after slave address frame
// - ack check on, ack one received sets
// - arbitration lost flag with enable sets
// - own address match, then each 9th rise
// - general call match, then each 9th rise
// - stop or error end sets, unless masked
// - serial format: sets at 8th clock rise
// - serial format: start condition sets
// - start in transmit mode with tx empty
// - tx empty or rx full rising sets
// - write zero after reading one clears
// - transfer controller data access clears
// - flag at control bit 1, resets 0
// - writing one to flag does nothing
`timescale 1ns/10ps
`default_nettype none

module twi_irq_flag (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	// bus lines
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	// configuration
	input  wire logic        format_select_i,
	input  wire logic        second_format_select_i,
	input  wire logic        wait_insert_i,
	input  wire logic        ack_check_enable_i,
	input  wire logic        arb_lost_irq_enable_i,
	input  wire logic        end_irq_mask_i,
	input  wire logic        transmit_i,
	input  wire logic        start_issued_i,
	// status flags of the controller
	input  wire logic        tx_empty_flag_i,
	input  wire logic        rx_full_flag_i,
	input  wire logic        received_ack_bit_i,
	input  wire logic        arb_lost_flag_i,
	input  wire logic        addr_match_flag_i,
	input  wire logic        second_addr_match_flag_i,
	input  wire logic        general_call_flag_i,
	input  wire logic        stop_seen_flag_i,
	input  wire logic        error_end_seen_flag_i,
	// software access to the control register
	input  wire logic        ctrl_read_i,
	input  wire logic        ctrl_write_i,
	input  wire logic        ctrl_wflag_i,
	// transfer controller access to the data register
	input  wire logic        xfer_data_access_i,
	input  wire logic        xfer_clear_en_i,
	// results
	output logic             irq_request_flag_o,
	output logic [7:0]       ctrl_rdata_o,
	output logic             set_event_o
);

	////////////////////////////////////////////////////////////////
	// format decode

	function automatic logic is_sync(input logic fs, input logic second_format_select);
		is_sync = ({fs, second_format_select} == twi_pkg::FMT_SYNC);
	endfunction

	typedef struct packed {
		logic                 flag;
		logic                 read_one;
		logic [3:0]           cnt;
		twi_pkg::twi_phase_e  phase;
		logic                 slave_rep;
		logic                 start_pend;
		logic                 lost_pend;
		logic [8:0]           prev;
	} twi_flag_s;

	twi_flag_s st_q;
	twi_flag_s st_d;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [8:0] flags;
	logic [8:0] rise;
	logic       sync_fmt;
	logic       rise_8;
	logic       rise_9;
	logic       fall_8;
	logic       set_any;
	logic       clr_any;

	twi_line_sense u_sense (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.scl_i       (scl_i),
		.sda_i       (sda_i),
		.scl_rise_o  (scl_rise),
		.scl_fall_o  (scl_fall),
		.start_det_o (start_det),
		.stop_det_o  (stop_det)
	);

	assign flags = {error_end_seen_flag_i, stop_seen_flag_i,
		general_call_flag_i, second_addr_match_flag_i,
		addr_match_flag_i, arb_lost_flag_i, received_ack_bit_i,
		rx_full_flag_i, tx_empty_flag_i};

	// flags share our clock, so edges need no synchroniser
	genvar gi;
	generate
		for (gi = 0; gi < twi_pkg::N_FLAGS; gi++) begin : g_rise
			assign rise[gi] = flags[gi] & ~st_q.prev[gi];
		end
	endgenerate

	assign sync_fmt = is_sync(format_select_i, second_format_select_i);
	assign rise_8   = scl_rise & (st_q.cnt == twi_pkg::CNT_SEVEN);
	assign rise_9   = scl_rise & (st_q.cnt == twi_pkg::CNT_EIGHT);
	assign fall_8   = scl_fall & (st_q.cnt == twi_pkg::CNT_EIGHT);

	////////////////////////////////////////////////////////////////
	// set sources

	always_comb begin
		set_any = 1'h0;
		if (sync_fmt) begin
			set_any = set_any | rise_8;
			set_any = set_any | start_det;
		end else begin
			// wait mode moves the frame interrupt to the 8th fall
			if (wait_insert_i) begin
				set_any = set_any | fall_8;
			end else begin
				set_any = set_any | rise_9;
			end
			set_any = set_any | (st_q.lost_pend & rise_9);
			set_any = set_any | rise[twi_pkg::F_AM]
				| rise[twi_pkg::F_AM2];
			set_any = set_any | rise[twi_pkg::F_GC];
			set_any = set_any | (st_q.slave_rep & rise_9);
			set_any = set_any | ((end_irq_mask_i == twi_pkg::END_MASK_EN)
				& (rise[twi_pkg::F_STOP] | rise[twi_pkg::F_ERROR_END_SEEN_FLAG]));
		end
		set_any = set_any | (st_q.start_pend & rise[twi_pkg::F_TXE]);
		set_any = set_any | (ack_check_enable_i
			& rise[twi_pkg::F_ACK]);
		set_any = set_any | (arb_lost_irq_enable_i
			& rise[twi_pkg::F_ARB]);
		set_any = set_any | (transmit_i & st_q.start_pend
			& rise[twi_pkg::F_TXE]);
		set_any = set_any | rise[twi_pkg::F_TXE]
			| rise[twi_pkg::F_RXF];
	end

	// a zero write after reading one, or an enabled transfer access, clears; a one is ignored
	assign clr_any = (ctrl_write_i & (ctrl_wflag_i == twi_pkg::CLEAR_VAL)
		& st_q.read_one)
		| (xfer_data_access_i & xfer_clear_en_i);

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d      = st_q;
		st_d.prev = flags;

		// set wins over any clear in the same cycle
		if (set_any) begin
			st_d.flag = 1'h1;
		end else if (clr_any) begin
			st_d.flag = twi_pkg::FLAG_RST;
		end

		if (ctrl_read_i & st_q.flag) begin
			st_d.read_one = 1'h1;
		end else if (ctrl_write_i) begin
			st_d.read_one = 1'h0;
		end

		if (scl_rise) begin
			if ((st_q.cnt == twi_pkg::CNT_NINE)
				|| (sync_fmt && st_q.cnt == twi_pkg::CNT_EIGHT)) begin
				st_d.cnt = twi_pkg::CNT_ONE;
			end else begin
				st_d.cnt = st_q.cnt + twi_pkg::CNT_ONE;
			end
		end

		if (arb_lost_flag_i & ~st_q.prev[twi_pkg::F_ARB]) begin
			st_d.lost_pend = 1'h1;
		end
		if (rise[twi_pkg::F_AM] | rise[twi_pkg::F_AM2]
			| rise[twi_pkg::F_GC]) begin
			st_d.slave_rep = 1'h1;
		end

		case (st_q.phase)
			twi_pkg::TWI_IDLE: begin
				st_d.slave_rep = 1'h0;
			end
			twi_pkg::TWI_ADDR: begin
				if (rise_9) begin
					st_d.phase     = twi_pkg::TWI_DATA;
					st_d.lost_pend = 1'h0;
				end
			end
			twi_pkg::TWI_DATA: begin
			end
			default: begin
				st_d.phase = twi_pkg::TWI_IDLE;
			end
		endcase

		if (st_q.start_pend & rise[twi_pkg::F_TXE]) begin
			st_d.start_pend = 1'h0;
		end

		// start or stop ends any repeated slave interrupts
		if (start_det) begin
			st_d.phase      = twi_pkg::TWI_ADDR;
			st_d.cnt        = twi_pkg::CNT_ZERO;
			st_d.slave_rep  = 1'h0;
			st_d.start_pend = start_issued_i | transmit_i;
		end else if (stop_det) begin
			st_d.phase      = twi_pkg::TWI_IDLE;
			st_d.cnt        = twi_pkg::CNT_ZERO;
			st_d.slave_rep  = 1'h0;
			st_d.lost_pend  = 1'h0;
			st_d.start_pend = 1'h0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q <= '{phase: twi_pkg::TWI_IDLE, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign irq_request_flag_o = st_q.flag;
	assign set_event_o        = set_any;

	always_comb begin
		ctrl_rdata_o                    = '0;
		ctrl_rdata_o[twi_pkg::FLAG_POS] = st_q.flag;
	end

	////////////////////////////////////////////////////////////////
	// checks

	sequence s_set;
		set_any;
	endsequence

	sequence s_flag_up;
		##1 irq_request_flag_o;
	endsequence

	property p_set_raises;
		@(posedge sys_clk_i) disable iff (reset_i)
		s_set |-> s_flag_up;
	endproperty

	AST_SET_WINS: assert property (p_set_raises)
		else $error("set event did not raise the flag");
	AST_ZERO_CLEARS: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(irq_request_flag_o && st_q.read_one && ctrl_write_i
		&& !ctrl_wflag_i && !set_any) |=> !irq_request_flag_o)
		else $error("zero write after read did not clear the flag");
	AST_ONE_IGNORED: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(irq_request_flag_o && ctrl_write_i && ctrl_wflag_i
		&& !xfer_data_access_i) |=> irq_request_flag_o)
		else $error("write of one changed the flag");
	AST_NO_UNREAD_CLEAR: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(irq_request_flag_o && !st_q.read_one
		&& !(xfer_data_access_i && xfer_clear_en_i))
		|=> irq_request_flag_o)
		else $error("flag cleared without a prior read of one");
	AST_XFER_CLEARS: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(xfer_data_access_i && xfer_clear_en_i && !set_any)
		|=> !irq_request_flag_o)
		else $error("transfer controller access did not clear");
	AST_RISE_SETS: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		($rose(rx_full_flag_i) || $rose(tx_empty_flag_i))
		|=> irq_request_flag_o)
		else $error("buffer transfer did not set the flag");
	AST_WAIT_8TH: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(!sync_fmt && wait_insert_i && scl_fall
		&& st_q.cnt == twi_pkg::CNT_EIGHT) |=> irq_request_flag_o)
		else $error("no flag at 8th fall in wait mode");
	AST_NOWAIT_9TH: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(!sync_fmt && !wait_insert_i && scl_rise
		&& st_q.cnt == twi_pkg::CNT_EIGHT) |=> irq_request_flag_o)
		else $error("no flag at 9th rise without wait");
	AST_SYNC_8TH: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(sync_fmt && scl_rise && st_q.cnt == twi_pkg::CNT_SEVEN)
		|=> (irq_request_flag_o && st_q.cnt == twi_pkg::CNT_EIGHT))
		else $error("no flag at 8th rise in serial format");
	AST_ARB_IRQ: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(arb_lost_irq_enable_i && $rose(arb_lost_flag_i))
		|=> irq_request_flag_o)
		else $error("arbitration loss did not set the flag");
	AST_STOP_IRQ: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		(!sync_fmt && end_irq_mask_i == twi_pkg::END_MASK_EN
		&& $rose(stop_seen_flag_i)) |=> irq_request_flag_o)
		else $error("unmasked stop did not set the flag");
	AST_RDATA_BIT: assert property (@(posedge sys_clk_i)
		disable iff (reset_i)
		ctrl_rdata_o == (8'h02 & {8{irq_request_flag_o}}))
		else $error("control readback does not show the flag");

endmodule

`default_nettype wire

// *** verif/twi_bus_model.sv ***
// twi_bus_model: far-side party that drives the two bus lines
// assumes: lines pulled up when idle; tasks are called one at a time
`timescale 1ns/10ps
`default_nettype none

module twi_bus_model (
	// bus lines
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	// start: data falls while clock high, then clock parks low
	task automatic do_start();
		sda_o = 1'b1;
		#20 scl_o = 1'b1;
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b0;
		#20;
	endtask
	// 80 ns clocks; data moves only while clock low, never a false start
	task automatic do_clk(input int n);
		repeat (n) begin
			sda_o = ~sda_o;
			#20 scl_o = 1'b1;
			#40 scl_o = 1'b0;
			#20;
		end
	endtask
	// stop: data rises while clock high, lines then stand high
	task automatic do_stop();
		sda_o = 1'b0;
		#20 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#20;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_twi_irq_flag.sv ***
// tb_twi_irq_flag: self-checking bench of the interrupt request flag
// assumes: twi_bus_model drives the lines; inputs change at falling edge
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, ac) begin \
	checks++; \
	if ((ac) !== (ex)) begin \
		n_fail++; \
		$display("mismatch %s exp %h got %h", nm, ex, ac); \
	end \
end

module tb_twi_irq_flag;
	logic       sys_clk_i;
	logic       reset_i;
	logic       scl_i;
	logic       sda_i;
	logic [1:0] fmt;
	logic       wt;
	logic       ack_check_enable;
	logic       arbe;
	logic       msk;
	logic       trs;
	logic       sti;
	logic [8:0] st;
	logic       rd;
	logic       wr;
	logic       wf;
	logic       xa;
	logic       xe;
	logic       flag;
	logic       set_ev;
	logic [7:0] rdata;
	int         n_fail = 0;
	int         checks = 0;
	int         cyc    = 0;

	always #5 sys_clk_i = ~sys_clk_i;
	// whole run needs about 1800 cycles; the ceiling leaves slack
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////
	twi_bus_model i_twi_bus_model (.scl_o(scl_i), .sda_o(sda_i));
	twi_irq_flag i_twi_irq_flag (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.scl_i(scl_i), .sda_i(sda_i),
		.format_select_i(fmt[1]), .second_format_select_i(fmt[0]),
		.wait_insert_i(wt), .ack_check_enable_i(ack_check_enable),
		.arb_lost_irq_enable_i(arbe), .end_irq_mask_i(msk),
		.transmit_i(trs), .start_issued_i(sti),
		.tx_empty_flag_i(st[twi_pkg::F_TXE]),
		.rx_full_flag_i(st[twi_pkg::F_RXF]),
		.received_ack_bit_i(st[twi_pkg::F_ACK]),
		.arb_lost_flag_i(st[twi_pkg::F_ARB]),
		.addr_match_flag_i(st[twi_pkg::F_AM]),
		.second_addr_match_flag_i(st[twi_pkg::F_AM2]),
		.general_call_flag_i(st[twi_pkg::F_GC]),
		.stop_seen_flag_i(st[twi_pkg::F_STOP]),
		.error_end_seen_flag_i(st[twi_pkg::F_ERROR_END_SEEN_FLAG]),
		.ctrl_read_i(rd), .ctrl_write_i(wr), .ctrl_wflag_i(wf),
		.xfer_data_access_i(xa), .xfer_clear_en_i(xe),
		.irq_request_flag_o(flag), .ctrl_rdata_o(rdata),
		.set_event_o(set_ev)
	);
	////////////////////////////////////////////////////////////////////
	task automatic wait_n(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic sw_read();
		@(negedge sys_clk_i);
		rd = 1'b1;
		@(negedge sys_clk_i);
		rd = 1'b0;
	endtask
	task automatic sw_write(input logic v);
		@(negedge sys_clk_i);
		wr = 1'b1;
		wf = v;
		@(negedge sys_clk_i);
		wr = 1'b0;
	endtask
	task automatic xfer(input logic en);
		@(negedge sys_clk_i);
		xa = 1'b1;
		xe = en;
		@(negedge sys_clk_i);
		xa = 1'b0;
	endtask
	// line events need 4 cycles to reach the flag, so settle first
	task automatic clr();
		wait_n(6);
		sw_read();
		sw_write(1'b0);
	endtask
	task automatic expect_flag(input logic ex);
		wait_n(6);
		`CHK("irq_request_flag", ex, flag)
	endtask
	task automatic set_st(input int i, input logic v);
		@(negedge sys_clk_i);
		st[i] = v;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		wait_n(1);
		`CHK("irq_request_flag", 1'b0, flag)
		`CHK("ctrl_rdata", 8'h00, rdata)
		$display("test reset done");
	endtask
	task automatic t_clear();
		set_st(twi_pkg::F_TXE, 1'b1);
		#1;
		`CHK("set_event", 1'b1, set_ev)
		expect_flag(1'b1);
		`CHK("set_event", 1'b0, set_ev)
		`CHK("ctrl_rdata", 8'h02, rdata)
		sw_write(1'b1);
		expect_flag(1'b1);
		sw_write(1'b0);
		expect_flag(1'b1);
		sw_read();
		sw_write(1'b0);
		expect_flag(1'b0);
		$display("test clear done");
	endtask
	task automatic t_race();
		set_st(twi_pkg::F_TXE, 1'b0);
		set_st(twi_pkg::F_RXF, 1'b1);
		wait_n(2);
		sw_read();
		@(negedge sys_clk_i);
		wr = 1'b1;
		wf = 1'b0;
		st[twi_pkg::F_TXE] = 1'b1;
		@(negedge sys_clk_i);
		wr = 1'b0;
		expect_flag(1'b1);
		xfer(1'b0);
		expect_flag(1'b1);
		xfer(1'b1);
		expect_flag(1'b0);
		st = 9'h000;
		$display("test race done");
	endtask
	task automatic t_gated();
		int src[4] = '{twi_pkg::F_ACK, twi_pkg::F_ARB,
			twi_pkg::F_STOP, twi_pkg::F_ERROR_END_SEEN_FLAG};
		for (int e = 0; e < 2; e++) begin
			ack_check_enable = e[0];
			arbe = e[0];
			msk = ~e[0];
			foreach (src[k]) begin
				set_st(src[k], 1'b1);
				expect_flag(e[0]);
				set_st(src[k], 1'b0);
				clr();
			end
		end
		$display("test gated done");
	endtask
	task automatic t_frames();
		i_twi_bus_model.do_start();
		i_twi_bus_model.do_clk(8);
		expect_flag(1'b0);
		i_twi_bus_model.do_clk(1);
		expect_flag(1'b1);
		clr();
		wt = 1'b1;
		i_twi_bus_model.do_start();
		i_twi_bus_model.do_clk(7);
		expect_flag(1'b0);
		i_twi_bus_model.do_clk(1);
		expect_flag(1'b1);
		clr();
		i_twi_bus_model.do_clk(1);
		expect_flag(1'b0);
		i_twi_bus_model.do_stop();
		$display("test frames done");
	endtask
	// wait mode on, so a 9th-rise set can only come from a match
	task automatic t_slave();
		int i;
		for (int k = 0; k < 3; k++) begin
			i = (k == 0) ? twi_pkg::F_AM
				: (k == 1) ? twi_pkg::F_AM2 : twi_pkg::F_GC;
			i_twi_bus_model.do_start();
			i_twi_bus_model.do_clk(8);
			clr();
			i_twi_bus_model.do_clk(1);
			set_st(i, 1'b1);
			expect_flag(1'b1);
			clr();
			set_st(i, 1'b0);
			i_twi_bus_model.do_clk(8);
			clr();
			i_twi_bus_model.do_clk(1);
			expect_flag(1'b1);
			clr();
			i_twi_bus_model.do_stop();
			i_twi_bus_model.do_start();
			i_twi_bus_model.do_clk(8);
			clr();
			i_twi_bus_model.do_clk(1);
			expect_flag(1'b0);
			i_twi_bus_model.do_stop();
		end
		$display("test slave done");
	endtask
	task automatic t_serial();
		fmt = 2'h3;
		wt = 1'b0;
		i_twi_bus_model.do_start();
		expect_flag(1'b1);
		clr();
		i_twi_bus_model.do_clk(8);
		expect_flag(1'b1);
		clr();
		i_twi_bus_model.do_clk(7);
		expect_flag(1'b0);
		i_twi_bus_model.do_stop();
		fmt = 2'h0;
		$display("test serial done");
	endtask
	task automatic t_master();
		wt = 1'b1;
		trs = 1'b1;
		sti = 1'b1;
		arbe = 1'b0;
		// the serial test's stop clock leaves the flag set
		clr();
		set_st(twi_pkg::F_ARB, 1'b1);
		i_twi_bus_model.do_start();
		set_st(twi_pkg::F_TXE, 1'b1);
		expect_flag(1'b1);
		clr();
		i_twi_bus_model.do_clk(8);
		clr();
		i_twi_bus_model.do_clk(1);
		expect_flag(1'b1);
		i_twi_bus_model.do_stop();
		$display("test master done");
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		sys_clk_i = 1'b0;
		reset_i   = 1'b1;
		fmt       = 2'h0;
		wt        = 1'b0;
		ack_check_enable      = 1'b0;
		arbe      = 1'b0;
		msk       = 1'b1;
		trs       = 1'b0;
		sti       = 1'b0;
		st        = 9'h000;
		rd        = 1'b0;
		wr        = 1'b0;
		wf        = 1'b0;
		xa        = 1'b0;
		xe        = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		reset_i = 1'b0;
		t_reset();
		t_clear();
		t_race();
		t_gated();
		t_frames();
		t_slave();
		t_serial();
		t_master();
		wrap_up();
	end
endmodule
`default_nettype wire
